/* src/ccq_consts.svh */
`ifndef CCQ_CONSTS_SVH
`define CCQ_CONSTS_SVH

// bus addressing
`define CCQ_BCAST_ADDR 7'h7e
`define CCQ_NO_STATIC_ADDR 7'h00

// direct command codes, one per command served here
`define CCQ_CCC_GETBCR 8'h8e
`define CCQ_CCC_GETDCR 8'h8f
`define CCQ_CCC_STATUS 8'h90
`define CCQ_CCC_GETACCMST 8'h91
`define CCQ_CCC_SETBRGTGT 8'h93
`define CCQ_CCC_GETMXDS 8'h94

// status word layout
`define CCQ_ST_VENDOR_HI 15
`define CCQ_ST_VENDOR_LO 8
`define CCQ_ST_ACT_HI 7
`define CCQ_ST_ACT_LO 6
`define CCQ_ST_PERR 5
`define CCQ_ST_RSVD 4
`define CCQ_ST_IRQ_HI 3
`define CCQ_ST_IRQ_LO 0
`define CCQ_ST_RSVD_VAL 1'b0
`define CCQ_IRQ_NONE 4'h0

// bus characteristics bit that enables the speed query
`define CCQ_BCR_MXDS_BIT 0

// speed byte layout
`define CCQ_MX_RATE_HI 2
`define CCQ_MX_RATE_LO 0
`define CCQ_MX_TSCO_HI 5
`define CCQ_MX_TSCO_LO 3

// frame shape
`define CCQ_BITS_PER_BYTE 4'h8
`define CCQ_MXDS_LAST_SHORT 3'h1
`define CCQ_MXDS_LAST_LONG 3'h4
`define CCQ_STATUS_LAST 3'h1
`define CCQ_SINGLE_LAST 3'h0
`define CCQ_BRG_ENTRY_LAST 2'h2

`endif

/* src/ccq_pkg.sv */
package ccq_pkg;

   typedef enum logic [2:0] {
      CCQ_IDLE = 3'b000,
      CCQ_ADDR = 3'b001,
      CCQ_ACK = 3'b010,
      CCQ_WR = 3'b011,
      CCQ_RD = 3'b100,
      CCQ_END = 3'b101
   } ccq_phase_e;

   typedef enum logic [1:0] {
      CCQ_MD_NONE = 2'b00,
      CCQ_MD_CCC = 2'b01,
      CCQ_MD_BRG = 2'b10,
      CCQ_MD_GET = 2'b11
   } ccq_mode_e;

   typedef struct packed {
      logic [2:0] wr_rate;
      logic [2:0] rd_rate;
      logic [2:0] tsco;
      logic turn_en;
      logic [23:0] turn_us;
   } ccq_mxds_s;

   typedef struct packed {
      logic [6:0] addr;
      logic [15:0] id;
   } ccq_brg_s;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } ccq_sync_s;

   typedef struct packed {
      ccq_phase_e phase;
      ccq_mode_e mode;
      logic [3:0] cnt;
      logic ackd;
      logic [7:0] sh;
      logic [7:0] ccc;
      logic have_ccc;
      logic busy;
      logic scl_p;
      logic sda_p;
      logic [2:0] bidx;
      logic [2:0] last_idx;
      logic [15:0] stat;
      logic [7:0] brg_left;
      logic [1:0] brg_pos;
      logic brg_first;
      ccq_brg_s brg_cur;
      ccq_brg_s brg_out;
      logic brg_vld;
      logic perr;
      logic hand;
      logic grant;
      logic sda_o;
      logic sda_oe;
   } ccq_main_s;

endpackage : ccq_pkg

/* src/ccq_sync.sv */
`timescale 1ns/1ns
module ccq_sync (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_s,
   output logic sda_s
);
   ccq_pkg::ccq_sync_s q_q;
   ccq_pkg::ccq_sync_s q_d;

   // first stage feeds the second stage only
   always_comb begin
      q_d = q_q;
      q_d.s1 = {scl_i, sda_i};
      q_d.s2 = q_q.s1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q_q <= '0;
      end else if (ce) begin
         q_q <= q_d;
      end
   end

   assign scl_s = q_q.s2[1];
   assign sda_s = q_q.s2[0];
endmodule : ccq_sync

/* src/ccq_status.sv */
`timescale 1ns/1ns
`include "ccq_consts.svh"
module ccq_status (
   input wire logic [7:0] vendor_stat,
   input wire logic [1:0] act_mode,
   input wire logic perr,
   input wire logic [15:1] irq_pend,
   output logic [15:0] stat_word
);
   // lowest pending number wins: number 1 is the most urgent
   function automatic logic [3:0] top_irq(input logic [15:1] p);
      logic [3:0] n;
      n = `CCQ_IRQ_NONE;
      for (int i = 15; i >= 1; i--) begin
         if (p[i]) begin
            n = 4'(i);
         end
      end
      return n;
   endfunction : top_irq

   always_comb begin
      stat_word = '0;
      stat_word[`CCQ_ST_VENDOR_HI:`CCQ_ST_VENDOR_LO] = vendor_stat;
      stat_word[`CCQ_ST_ACT_HI:`CCQ_ST_ACT_LO] = act_mode;
      stat_word[`CCQ_ST_PERR] = perr;
      stat_word[`CCQ_ST_RSVD] = `CCQ_ST_RSVD_VAL;
      stat_word[`CCQ_ST_IRQ_HI:`CCQ_ST_IRQ_LO] = top_irq(irq_pend);
   end
endmodule : ccq_status

/* src/ccq_responder.sv */
`timescale 1ns/1ns
`include "ccq_consts.svh"
module ccq_responder (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [6:0] dyn_addr,
   input wire logic dyn_valid,
   input wire logic [6:0] static_addr,
   input wire logic static_valid,
   input wire logic [7:0] bcr,
   input wire logic [7:0] dcr,
   input wire logic [7:0] vendor_stat,
   input wire logic [1:0] act_mode,
   input wire logic [15:1] irq_pend,
   input wire logic err_evt,
   input wire logic accept_mst,
   input wire ccq_pkg::ccq_mxds_s mxds,
   output logic proto_err,
   output logic mst_grant,
   output logic brg_vld,
   output ccq_pkg::ccq_brg_s brg_entry
);
   ccq_pkg::ccq_main_s q_q;
   ccq_pkg::ccq_main_s q_d;
   logic scl_s;
   logic sda_s;
   logic [15:0] stat_word;
   logic rise;
   logic fall;
   logic start_ev;
   logic stop_ev;

   ccq_sync u_sync (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_s(scl_s),
      .sda_s(sda_s)
   );

   ccq_status u_status (
      .vendor_stat(vendor_stat),
      .act_mode(act_mode),
      .perr(q_q.perr),
      .irq_pend(irq_pend),
      .stat_word(stat_word)
   );

   // bus events seen on the synchronised copies only
   assign rise = scl_s & ~q_q.scl_p;
   assign fall = ~scl_s & q_q.scl_p;
   assign start_ev = scl_s & q_q.scl_p & q_q.sda_p & ~sda_s;
   assign stop_ev = scl_s & q_q.scl_p & ~q_q.sda_p & sda_s;

   // which direct reads we answer at all
   function automatic logic get_ok(input logic [7:0] cmd);
      logic ok;
      ok = 1'b0;
      if (cmd == `CCQ_CCC_GETBCR || cmd == `CCQ_CCC_GETDCR) begin
         ok = 1'b1;
      end else if (cmd == `CCQ_CCC_STATUS) begin
         ok = 1'b1;
      end else if (cmd == `CCQ_CCC_GETACCMST) begin
         ok = accept_mst;
      end else if (cmd == `CCQ_CCC_GETMXDS) begin
         ok = bcr[`CCQ_BCR_MXDS_BIT];
      end
      return ok;
   endfunction : get_ok

   // index of the final data byte; its count tells the master the format
   function automatic logic [2:0] last_of(input logic [7:0] cmd);
      logic [2:0] n;
      n = `CCQ_SINGLE_LAST;
      if (cmd == `CCQ_CCC_STATUS) begin
         n = `CCQ_STATUS_LAST;
      end else if (cmd == `CCQ_CCC_GETMXDS) begin
         n = mxds.turn_en ? `CCQ_MXDS_LAST_LONG
                          : `CCQ_MXDS_LAST_SHORT;
      end
      return n;
   endfunction : last_of

   function automatic logic [7:0] get_byte(input logic [7:0] cmd,
                                           input logic [2:0] idx,
                                           input logic [15:0] st);
      logic [7:0] b;
      b = '0;
      if (cmd == `CCQ_CCC_GETBCR) begin
         b = bcr;
      end else if (cmd == `CCQ_CCC_GETDCR) begin
         b = dcr;
      end else if (cmd == `CCQ_CCC_STATUS) begin
         b = (idx == 3'h0) ? st[15:8] : st[7:0];
      end else if (cmd == `CCQ_CCC_GETACCMST) begin
         b = {dyn_addr, ~^dyn_addr};
      end else if (cmd == `CCQ_CCC_GETMXDS) begin
         case (idx)
            3'h0: begin
               b[`CCQ_MX_RATE_HI:`CCQ_MX_RATE_LO] = mxds.wr_rate;
            end
            3'h1: begin
               b[`CCQ_MX_RATE_HI:`CCQ_MX_RATE_LO] = mxds.rd_rate;
               b[`CCQ_MX_TSCO_HI:`CCQ_MX_TSCO_LO] = mxds.tsco;
            end
            3'h2: b = mxds.turn_us[7:0];
            3'h3: b = mxds.turn_us[15:8];
            default: b = mxds.turn_us[23:16];
         endcase
      end
      return b;
   endfunction : get_byte

   always_comb begin
      logic [7:0] byte_in;
      logic [7:0] b;
      logic perr_set;
      logic perr_clr;
      byte_in = {q_q.sh[6:0], sda_s};
      b = '0;
      perr_set = err_evt;
      perr_clr = 1'b0;
      q_d = q_q;
      q_d.grant = 1'b0;
      q_d.brg_vld = 1'b0;
      q_d.scl_p = scl_s;
      q_d.sda_p = sda_s;
      if (stop_ev) begin
         q_d.grant = q_q.hand;
         q_d.hand = 1'b0;
         q_d.phase = ccq_pkg::CCQ_IDLE;
         q_d.mode = ccq_pkg::CCQ_MD_NONE;
         q_d.busy = 1'b0;
         q_d.have_ccc = 1'b0;
         q_d.sda_oe = 1'b0;
      end else if (start_ev) begin
         // a fresh start forgets the command; a repeated one keeps it
         if (!q_q.busy) begin
            q_d.have_ccc = 1'b0;
         end
         q_d.hand = 1'b0;
         q_d.busy = 1'b1;
         q_d.phase = ccq_pkg::CCQ_ADDR;
         q_d.cnt = '0;
         q_d.sda_oe = 1'b0;
      end else begin
         case (q_q.phase)
            ccq_pkg::CCQ_ADDR: begin
               if (rise) begin
                  q_d.sh = byte_in;
                  q_d.cnt = q_q.cnt + 4'h1;
                  if (q_q.cnt == `CCQ_BITS_PER_BYTE - 4'h1) begin
                     q_d.phase = ccq_pkg::CCQ_IDLE;
                     q_d.ackd = 1'b0;
                     if (byte_in[7:1] == `CCQ_BCAST_ADDR && !byte_in[0]) begin
                        q_d.phase = ccq_pkg::CCQ_ACK;
                        q_d.mode = ccq_pkg::CCQ_MD_CCC;
                     end else if (q_q.have_ccc && byte_in[0] && dyn_valid &&
                                  byte_in[7:1] == dyn_addr &&
                                  get_ok(q_q.ccc)) begin
                        q_d.phase = ccq_pkg::CCQ_ACK;
                        q_d.mode = ccq_pkg::CCQ_MD_GET;
                        q_d.stat = stat_word;
                        q_d.bidx = '0;
                        q_d.last_idx = last_of(q_q.ccc);
                     end else if (q_q.have_ccc && !byte_in[0] &&
                                  q_q.ccc == `CCQ_CCC_SETBRGTGT &&
                                  byte_in[7:1] == (static_valid ? static_addr
                                  : `CCQ_NO_STATIC_ADDR)) begin
                        q_d.phase = ccq_pkg::CCQ_ACK;
                        q_d.mode = ccq_pkg::CCQ_MD_BRG;
                        q_d.brg_first = 1'b1;
                        q_d.brg_pos = '0;
                     end
                  end
               end
            end
            ccq_pkg::CCQ_ACK: begin
               if (fall) begin
                  if (!q_q.ackd) begin
                     q_d.ackd = 1'b1;
                     q_d.sda_o = 1'b0;
                     q_d.sda_oe = 1'b1;
                  end else if (q_q.mode == ccq_pkg::CCQ_MD_GET) begin
                     b = get_byte(q_q.ccc, 3'h0, q_q.stat);
                     q_d.phase = ccq_pkg::CCQ_RD;
                     q_d.sda_o = b[7];
                     q_d.sh = {b[6:0], 1'b0};
                     q_d.cnt = '0;
                  end else begin
                     q_d.phase = ccq_pkg::CCQ_WR;
                     q_d.sda_oe = 1'b0;
                     q_d.cnt = '0;
                  end
               end
            end
            ccq_pkg::CCQ_WR: begin
               if (rise) begin
                  if (q_q.cnt != `CCQ_BITS_PER_BYTE) begin
                     q_d.sh = byte_in;
                     q_d.cnt = q_q.cnt + 4'h1;
                  end else begin
                     // ninth bit is the master's odd parity
                     q_d.cnt = '0;
                     perr_set = perr_set | ~(^{q_q.sh, sda_s});
                     if (q_q.mode == ccq_pkg::CCQ_MD_CCC) begin
                        q_d.ccc = q_q.sh;
                        q_d.have_ccc = 1'b1;
                        q_d.mode = ccq_pkg::CCQ_MD_NONE;
                     end else if (q_q.mode == ccq_pkg::CCQ_MD_BRG) begin
                        if (q_q.brg_first) begin
                           q_d.brg_first = 1'b0;
                           q_d.brg_left = q_q.sh;
                        end else if (q_q.brg_left != 8'h00) begin
                           q_d.brg_pos = q_q.brg_pos + 2'h1;
                           case (q_q.brg_pos)
                              2'h0: q_d.brg_cur.addr = q_q.sh[7:1];
                              2'h1: q_d.brg_cur.id[15:8] = q_q.sh;
                              default: begin
                                 q_d.brg_out = {q_q.brg_cur.addr,
                                                q_q.brg_cur.id[15:8], q_q.sh};
                                 q_d.brg_vld = 1'b1;
                                 q_d.brg_pos = '0;
                                 q_d.brg_left = q_q.brg_left - 8'h01;
                              end
                           endcase
                        end
                     end
                  end
               end
            end
            ccq_pkg::CCQ_RD: begin
               if (rise) begin
                  if (q_q.cnt == `CCQ_BITS_PER_BYTE) begin
                     if (q_q.bidx == q_q.last_idx) begin
                        q_d.phase = ccq_pkg::CCQ_END;
                        if (q_q.ccc == `CCQ_CCC_STATUS) begin
                           perr_clr = 1'b1;
                        end
                        if (q_q.ccc == `CCQ_CCC_GETACCMST) begin
                           q_d.hand = 1'b1;
                        end
                     end else begin
                        q_d.bidx = q_q.bidx + 3'h1;
                        q_d.sh = get_byte(q_q.ccc, q_q.bidx + 3'h1, q_q.stat);
                        q_d.cnt = '0;
                     end
                  end else begin
                     q_d.cnt = q_q.cnt + 4'h1;
                  end
               end else if (fall) begin
                  if (q_q.cnt < `CCQ_BITS_PER_BYTE) begin
                     q_d.sda_o = q_q.sh[7];
                     q_d.sh = {q_q.sh[6:0], 1'b0};
                  end else begin
                     // end-of-data bit: high means more bytes follow
                     q_d.sda_o = (q_q.bidx != q_q.last_idx);
                  end
               end
            end
            ccq_pkg::CCQ_END: begin
               if (fall) begin
                  q_d.sda_oe = 1'b0;
                  q_d.phase = ccq_pkg::CCQ_IDLE;
               end
            end
            default: begin
               q_d.sda_oe = 1'b0;
            end
         endcase
      end
      // a new error in the clearing cycle survives
      q_d.perr = (q_q.perr & ~perr_clr) | perr_set;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q_q <= '0;
      end else if (ce) begin
         q_q <= q_d;
      end
   end

   assign sda_o = q_q.sda_o;
   assign sda_oe = q_q.sda_oe;
   assign proto_err = q_q.perr;
   assign mst_grant = q_q.grant;
   assign brg_vld = q_q.brg_vld;
   assign brg_entry = q_q.brg_out;
endmodule : ccq_responder

/* tb/ccq_responder_sva.sv */
`timescale 1ns/1ns
module ccq_responder_sva (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic dyn_valid,
   input wire logic err_evt,
   input wire logic accept_mst,
   input wire logic proto_err,
   input wire logic mst_grant,
   input wire logic brg_vld
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_reset_quiet: assert property ($rose(rstn) |->
      !sda_oe && !mst_grant && !brg_vld && !proto_err)
      else $error("outputs active right after reset");
   a_idle_released: assert property ((scl_i && sda_i)[*8] |-> !sda_oe)
      else $error("data line driven while bus idle");
   // drive changes only in the low half of the bus clock
   a_drive_scl_low: assert property (($rose(sda_oe) || $fell(sda_oe) ||
      (sda_oe && $changed(sda_o))) |-> !scl_i)
      else $error("data line changed while bus clock high");
   a_perr_sets: assert property (ce && err_evt |=> proto_err)
      else $error("error event did not set the error flag");
   a_perr_clear: assert property ($fell(proto_err) |->
      $past(sda_oe) && !$past(err_evt))
      else $error("error flag cleared outside a status read");
   a_grant_pulse: assert property (mst_grant |=> !mst_grant)
      else $error("grant longer than one cycle");
   a_grant_cond: assert property (mst_grant |->
      accept_mst && dyn_valid && scl_i && sda_i)
      else $error("grant without accept or before stop");
   a_brg_pulse: assert property (brg_vld |=> !brg_vld)
      else $error("bridge entry strobe longer than one cycle");
endmodule : ccq_responder_sva

bind ccq_responder ccq_responder_sva u_ccq_responder_sva (
   .clk(clk), .rstn(rstn), .ce(ce), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .dyn_valid(dyn_valid),
   .err_evt(err_evt), .accept_mst(accept_mst), .proto_err(proto_err),
   .mst_grant(mst_grant), .brg_vld(brg_vld));

/* tb/ccq_master_model.sv */
`timescale 1ns/1ns
module ccq_master_model (
   output logic scl,
   output logic sda_m,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // data moves mid-low, sampled mid-high; scl stands high between frames
   task automatic bit_io(input logic b, output logic r);
      #100 sda_m = b;
      #100 scl = 1'b1;
      #100 r = sda;
      #100 scl = 1'b0;
   endtask : bit_io
   task automatic start();
      #37 sda_m = 1'b0;
      #200 scl = 1'b0;
   endtask : start
   task automatic rstart();
      #100 sda_m = 1'b1;
      #100 scl = 1'b1;
      #200 sda_m = 1'b0;
      #200 scl = 1'b0;
   endtask : rstart
   task automatic stop();
      #100 sda_m = 1'b0;
      #100 scl = 1'b1;
      #200 sda_m = 1'b1;
      #400;
   endtask : stop
   // par9 sends odd parity as ninth bit, else ninth bit is the ack
   task automatic put(input logic [7:0] b, input logic par9, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(par9 ? ~^b : 1'b1, r);
      ack = !r;
   endtask : put
   task automatic get(output logic [7:0] b, output logic t);
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(1'b1, t);
   endtask : get
   task automatic query(input logic [7:0] ccc, input logic [6:0] addr,
         input logic rs_end, output logic ack, output int n,
         output logic [39:0] d);
      logic a;
      logic t;
      logic [7:0] b;
      n = 0;
      d = '0;
      t = 1'b1;
      start();
      put({7'h7e, 1'b0}, 1'b0, a);
      put(ccc, 1'b1, a);
      rstart();
      put({addr, 1'b1}, 1'b0, ack);
      while (ack && t && n < 5) begin
         get(b, t);
         d = {d[31:0], b};
         n++;
      end
      // a repeated start here cancels a handoff before the stop
      if (rs_end) begin
         rstart();
      end
      stop();
   endtask : query
endmodule : ccq_master_model

/* tb/ccq_responder_tb_top.sv */
`timescale 1ns/1ns
`include "ccq_consts.svh"
module ccq_responder_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic scl, sda_m, sda, sda_o, sda_oe, proto_err, mst_grant, brg_vld;
   logic [6:0] dyn_addr = 7'h2a;
   logic dyn_valid = 1'b1;
   logic [6:0] static_addr = 7'h51;
   logic static_valid = 1'b1;
   logic [7:0] bcr = 8'ha5;
   logic [7:0] dcr = 8'h3c;
   logic [7:0] vendor_stat = 8'hc3;
   logic [1:0] act_mode = 2'b10;
   logic [15:1] irq_pend = '0;
   logic err_evt = 1'b0;
   logic accept_mst = 1'b1;
   ccq_pkg::ccq_mxds_s mxds = {3'd1, 3'd4, 3'd2, 1'b0, 24'h123456};
   ccq_pkg::ccq_brg_s brg_entry;
   ccq_pkg::ccq_brg_s bq[$];
   int err_total = 0;
   int n_compared = 0;
   int n_grant = 0;

   always #25 clk = ~clk;
   // pull-up on the data wire: released means high
   assign sda = (sda_oe ? sda_o : 1'b1) & sda_m;

   ccq_responder u_ccq_responder (
      .clk(clk), .rstn(rstn), .ce(ce), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .dyn_addr(dyn_addr),
      .dyn_valid(dyn_valid), .static_addr(static_addr),
      .static_valid(static_valid), .bcr(bcr), .dcr(dcr),
      .vendor_stat(vendor_stat), .act_mode(act_mode),
      .irq_pend(irq_pend), .err_evt(err_evt), .accept_mst(accept_mst),
      .mxds(mxds), .proto_err(proto_err), .mst_grant(mst_grant),
      .brg_vld(brg_vld), .brg_entry(brg_entry));

   ccq_master_model u_ccq_master_model (
      .scl(scl), .sda_m(sda_m), .sda(sda));

   // sample strobes mid-cycle, well clear of the launching edge
   always @(negedge clk) begin
      if (brg_vld === 1'b1) begin
         bq.push_back(brg_entry);
      end
      if (mst_grant === 1'b1) begin
         n_grant++;
      end
   end

   task automatic finish_test();
      $display("compared=%0d errors=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   task automatic tick();
      @(posedge clk);
      #2;
   endtask : tick

   task automatic q(input logic [7:0] ccc, input logic [6:0] a,
         input logic rs, input logic ea, input int en,
         input logic [39:0] ed);
      logic ack;
      int n;
      logic [39:0] d;
      u_ccq_master_model.query(ccc, a, rs, ack, n, d);
      chk({ack, n[6:0], d}, {ea, en[6:0], ed});
      tick();
   endtask : q

   // count 2; a dynamic entry, then a legacy entry with address zero
   task automatic brg(input logic [6:0] sa, input logic ea);
      logic [7:0] pl [7] = '{8'h02, 8'h54, 8'h12, 8'h34, 8'h00, 8'hab, 8'hcd};
      logic a;
      logic ok;
      u_ccq_master_model.start();
      u_ccq_master_model.put({7'h7e, 1'b0}, 1'b0, a);
      u_ccq_master_model.put(`CCQ_CCC_SETBRGTGT, 1'b1, a);
      u_ccq_master_model.rstart();
      u_ccq_master_model.put({sa, 1'b0}, 1'b0, a);
      chk(48'(a), 48'(ea));
      ok = a;
      // ninth bit of a written byte is parity, not an acknowledge
      for (int i = 0; i < 7 && ok; i++) begin
         u_ccq_master_model.put(pl[i], 1'b1, a);
      end
      u_ccq_master_model.rstart();
      u_ccq_master_model.stop();
      tick();
   endtask : brg

   initial begin
      #3000000;
      err_total++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      #2 rstn = 1'b1;
      repeat (4) tick();
      q(`CCQ_CCC_GETBCR, 7'h2a, 1'b0, 1'b1, 1, 40'(bcr));
      q(`CCQ_CCC_GETDCR, 7'h2a, 1'b1, 1'b1, 1, 40'(dcr));
      q(`CCQ_CCC_GETBCR, 7'h2b, 1'b0, 1'b0, 0, 40'h0);
      dyn_valid = 1'b0;
      q(`CCQ_CCC_GETBCR, 7'h2a, 1'b0, 1'b0, 0, 40'h0);
      dyn_valid = 1'b1;
      err_evt = 1'b1;
      irq_pend[5] = 1'b1;
      irq_pend[9] = 1'b1;
      tick();
      err_evt = 1'b0;
      chk(48'(proto_err), 48'h1);
      q(`CCQ_CCC_STATUS, 7'h2a, 1'b0, 1'b1, 2,
         {8'hc3, 2'b10, 1'b1, 1'b0, 4'h5});
      chk(48'(proto_err), 48'h0);
      irq_pend = '0;
      act_mode = 2'b01;
      vendor_stat = 8'h5e;
      q(`CCQ_CCC_STATUS, 7'h2a, 1'b0, 1'b1, 2,
         {8'h5e, 2'b01, 1'b0, 1'b0, 4'h0});
      q(`CCQ_CCC_GETMXDS, 7'h2a, 1'b0, 1'b1, 2,
         {5'h0, 3'd1, 2'b00, 3'd2, 3'd4});
      mxds.turn_en = 1'b1;
      q(`CCQ_CCC_GETMXDS, 7'h2a, 1'b0, 1'b1, 5,
         {5'h0, 3'd1, 2'b00, 3'd2, 3'd4, 8'h56, 8'h34, 8'h12});
      bcr = 8'ha4;
      q(`CCQ_CCC_GETMXDS, 7'h2a, 1'b0, 1'b0, 0, 40'h0);
      q(`CCQ_CCC_GETACCMST, 7'h2a, 1'b1, 1'b1, 1,
         {7'h2a, ~^7'h2a});
      accept_mst = 1'b0;
      q(`CCQ_CCC_GETACCMST, 7'h2a, 1'b0, 1'b0, 0, 40'h0);
      repeat (20) tick();
      chk(48'(n_grant), 48'h0);
      accept_mst = 1'b1;
      q(`CCQ_CCC_GETACCMST, 7'h2a, 1'b0, 1'b1, 1,
         {7'h2a, ~^7'h2a});
      repeat (20) tick();
      chk(48'(n_grant), 48'h1);
      brg(7'h51, 1'b1);
      static_valid = 1'b0;
      brg(7'h51, 1'b0);
      brg(7'h00, 1'b1);
      chk(48'(bq.size()), 48'h4);
      for (int i = 0; i < bq.size(); i++) begin
         chk(48'(bq[i]), i[0] ? 48'(23'h00abcd) : 48'(23'h2a1234));
      end
      finish_test();
   end
endmodule : ccq_responder_tb_top
